// ### core/serial_write_pkg.sv
/*
  Constants and types shared by both ends of the three-wire serial write link.
  Assumes both ends run on the same 100 MHz system clock.
*/
// What this block does
// - Host serial clock never above 40 MHz.
// - Device accepts free-running or resting serial clock.
// - Frame sync low frames one 16-bit word.
// - Device samples data on falling clock edges.
// - Host changes data on rising clock edges.
// - MSB first: control, address, data byte.
// - Byte mode keeps frame low across two bytes.
// - Serial clock rests high between the bytes.
// - Host reorders bits so MSB goes first.
// - Frame sync is active low at device.
package serial_write_pkg;
  localparam int WORD_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam int CTRL_MSB = 15;
  localparam int CTRL_LSB = 12;
  localparam int ADDR_MSB = 11;
  localparam int ADDR_LSB = 8;
  localparam int DATA_MSB = 7;
  localparam int DATA_LSB = 0;
  localparam int SYS_CLK_MHZ = 100;
  localparam int SCLK_MAX_MHZ = 40;
  // Half period in system cycles, rounded up so the link never exceeds its limit
  localparam int SCLK_HALF_MIN = (SYS_CLK_MHZ + 2 * SCLK_MAX_MHZ - 1) / (2 * SCLK_MAX_MHZ);
  localparam int SCLK_HALF_DEF = 4;
  localparam int GAP_CYCLES_DEF = 4;
  localparam int FIFO_DEPTH_DEF = 32;
  localparam logic [4:0] BIT_CNT_RESET = 5'h00;
  typedef enum logic [2:0] {
    HOST_IDLE, HOST_SETUP, HOST_LOW, HOST_HIGH, HOST_GAP, HOST_END
  } host_state_type;
endpackage

// ### core/serial_write_if.sv
/*
  Three-wire write link between host and device.
  Assumes both modports are joined by the bench.
*/
`timescale 1ns/100ps
interface serial_write_if;
  logic serial_clk;
  logic frame_sync_n;
  logic serial_data_in;
  modport host (output serial_clk, output frame_sync_n, output serial_data_in);
  modport device (input serial_clk, input frame_sync_n, input serial_data_in);
endinterface

// ### core/word_fifo.sv
/*
  Flip-flop FIFO with valid/ready on both sides.
  Assumes one clock and synchronous active-low reset.
*/
`timescale 1ns/100ps
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input wire logic clk_sys_i, // System clock
  input wire logic reset_n_i, // Synchronous reset, active low
  input wire logic [WIDTH-1:0] in_data_i, // Write data
  input wire logic in_valid_i, // Write request
  output logic in_ready_o, // Not full
  output logic [WIDTH-1:0] out_data_o, // Read data
  output logic out_valid_o, // Not empty
  input wire logic out_ready_i // Read accept
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  wire do_wr = in_valid_i && in_ready_o;
  wire do_rd = out_valid_o && out_ready_i;
  assign in_ready_o = count_reg != (AW + 1)'(DEPTH);
  assign out_valid_o = count_reg != '0;
  assign out_data_o = mem_reg[rd_ptr_reg];
  always_ff @(posedge clk_sys_i) begin
    if (do_wr) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW + 1)'(do_wr) - (AW + 1)'(do_rd);
    end
  end
endmodule

// ### core/serial_write_device.sv
/*
  Device end: samples the serial link on the system clock, assembles 16-bit
  words and hands them to a FIFO toward the destination registers.
  Assumes link pins are asynchronous to clk_sys_i and serial clock at most 40 MHz.
*/
`timescale 1ns/100ps
module serial_write_device
  import serial_write_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input wire logic clk_sys_i, // System clock
  input wire logic reset_n_i, // Synchronous reset, active low
  serial_write_if.device link, // Serial link
  output logic [WORD_BITS-1:0] word_o, // Received word
  output logic [3:0] word_ctrl_o, // Control nibble of word
  output logic [3:0] word_addr_o, // Address nibble of word
  output logic [7:0] word_data_o, // Data byte of word
  output logic word_valid_o, // Word available
  input wire logic word_ready_i, // Word taken
  output logic overflow_o // Word dropped, FIFO full (pulse)
);
  logic [2:0] sclk_sync_reg;
  logic [2:0] fs_sync_reg;
  logic [2:0] sd_sync_reg;
  logic [WORD_BITS-1:0] shift_reg;
  logic [WORD_BITS-1:0] shift_next;
  logic [4:0] bit_cnt_reg;
  logic push_reg;
  logic [WORD_BITS-1:0] push_data_reg;
  logic overflow_reg;
  logic fifo_in_ready;
  //////////////////////////////////////////////////////////////////////////////
  // Stage 0 is only read by stage 1; edges are found between stages 1 and 2
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      sclk_sync_reg <= 3'h0;
      fs_sync_reg <= 3'h7;
      sd_sync_reg <= 3'h0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], link.serial_clk};
      fs_sync_reg <= {fs_sync_reg[1:0], link.frame_sync_n};
      sd_sync_reg <= {sd_sync_reg[1:0], link.serial_data_in};
    end
  end
  wire frame_active = !fs_sync_reg[1];
  // Falling edge only counts inside a frame, so clock level at rest is irrelevant
  wire sclk_fall = sclk_sync_reg[2] && !sclk_sync_reg[1] && frame_active;
  wire sample_bit = sd_sync_reg[2];
  wire last_bit = bit_cnt_reg == 5'(WORD_BITS - 1);
  assign shift_next = {shift_reg[WORD_BITS-2:0], sample_bit};
  // Falls past the sixteenth are ignored until the frame closes
  wire accept_edge = sclk_fall && bit_cnt_reg < 5'(WORD_BITS);
  wire word_done = accept_edge && last_bit;
  //////////////////////////////////////////////////////////////////////////////
  // Frame end before sixteen edges clears the partial word
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i || !frame_active) begin
      bit_cnt_reg <= BIT_CNT_RESET;
      shift_reg <= '0;
    end else if (accept_edge) begin
      bit_cnt_reg <= last_bit ? 5'(WORD_BITS) : bit_cnt_reg + 5'h01;
      shift_reg <= shift_next;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      push_reg <= 1'b0;
      push_data_reg <= '0;
      overflow_reg <= 1'b0;
    end else begin
      push_reg <= word_done && accept_edge && fifo_in_ready;
      overflow_reg <= word_done && accept_edge && !fifo_in_ready;
      if (word_done) begin
        push_data_reg <= shift_next;
      end
    end
  end
  assign overflow_o = overflow_reg;
  word_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) fifo_inst (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .in_data_i(push_data_reg),
    .in_valid_i(push_reg),
    .in_ready_o(fifo_in_ready),
    .out_data_o(word_o),
    .out_valid_o(word_valid_o),
    .out_ready_i(word_ready_i)
  );
  assign word_ctrl_o = word_o[CTRL_MSB:CTRL_LSB];
  assign word_addr_o = word_o[ADDR_MSB:ADDR_LSB];
  assign word_data_o = word_o[DATA_MSB:DATA_LSB];
endmodule

// ### core/serial_write_host.sv
/*
  Host end: takes words from a user port and shifts each out MSB first in one
  frame, optionally as two bytes with the clock resting high between them.
  Assumes the device samples on falling edges of the serial clock.
*/
`timescale 1ns/100ps
module serial_write_host
  import serial_write_pkg::*;
#(
  parameter int SCLK_HALF = SCLK_HALF_DEF,
  parameter int GAP_CYCLES = GAP_CYCLES_DEF
) (
  input wire logic clk_sys_i, // System clock
  input wire logic reset_n_i, // Synchronous reset, active low
  serial_write_if.host link, // Serial link
  input wire logic [WORD_BITS-1:0] tx_word_i, // Word to send
  input wire logic tx_valid_i, // Word offered
  output logic tx_ready_o, // Word accepted this cycle
  input wire logic byte_mode_i, // Send as two 8-bit transfers
  input wire logic lsb_first_i, // Source word is LSB first, reverse it
  output logic busy_o // Frame in progress
);
  host_state_type state_reg, state_next;
  logic [WORD_BITS-1:0] shift_reg;
  logic [4:0] bits_left_reg;
  logic [7:0] timer_reg;
  logic byte_mode_reg;
  logic sclk_reg, fs_n_reg;
  logic [WORD_BITS-1:0] rev_word;
  // SCLK_HALF below SCLK_HALF_MIN would violate the serial clock limit
  localparam logic [7:0] HALF = 8'(SCLK_HALF < SCLK_HALF_MIN ? SCLK_HALF_MIN : SCLK_HALF);
  localparam logic [7:0] GAP = 8'(GAP_CYCLES);
  for (genvar i = 0; i < WORD_BITS; i++) begin : g_rev
    assign rev_word[i] = tx_word_i[WORD_BITS-1-i];
  end
  wire timer_done = timer_reg == 8'h01;
  wire take = state_reg == HOST_IDLE && tx_valid_i;
  wire mid_gap = byte_mode_reg && bits_left_reg == 5'(BYTE_BITS);
  assign tx_ready_o = take;
  assign busy_o = state_reg != HOST_IDLE;
  assign link.serial_clk = sclk_reg;
  assign link.frame_sync_n = fs_n_reg;
  assign link.serial_data_in = shift_reg[WORD_BITS-1];
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      HOST_IDLE: if (take) state_next = HOST_SETUP;
      HOST_SETUP: if (timer_done) state_next = HOST_LOW;
      HOST_LOW: if (timer_done) state_next = HOST_HIGH;
      HOST_HIGH: begin
        if (timer_done) begin
          if (bits_left_reg == 5'h00) state_next = HOST_END;
          else if (mid_gap) state_next = HOST_GAP;
          else state_next = HOST_LOW;
        end
      end
      HOST_GAP: if (timer_done) state_next = HOST_LOW;
      HOST_END: if (timer_done) state_next = HOST_IDLE;
    endcase
  end
  //////////////////////////////////////////////////////////////////////////////
  // Clock rests high; data shifts on rising edge, device samples on falling.
  // Frame closes on entry to the end phase, so frames are kept apart by at least that phase.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      state_reg <= HOST_IDLE;
      shift_reg <= '0;
      bits_left_reg <= 5'h00;
      timer_reg <= 8'h00;
      byte_mode_reg <= 1'b0;
      sclk_reg <= 1'b1;
      fs_n_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      timer_reg <= (timer_done || state_reg == HOST_IDLE) ? HALF : timer_reg - 8'h01;
      if (take) begin
        shift_reg <= lsb_first_i ? rev_word : tx_word_i;
        bits_left_reg <= 5'(WORD_BITS);
        byte_mode_reg <= byte_mode_i;
        fs_n_reg <= 1'b0;
      end
      if (state_reg != state_next) begin
        unique case (state_next)
          HOST_LOW: begin
            sclk_reg <= 1'b0;
            bits_left_reg <= bits_left_reg - 5'h01;
          end
          HOST_HIGH: begin
            sclk_reg <= 1'b1;
            shift_reg <= {shift_reg[WORD_BITS-2:0], 1'b0};
          end
          HOST_GAP: sclk_reg <= 1'b1;
          HOST_END: fs_n_reg <= 1'b1;
          default: sclk_reg <= sclk_reg;
        endcase
        if (state_next == HOST_GAP) begin
          timer_reg <= GAP;
        end
      end
    end
  end
endmodule

// ### test/serial_write_props.sv
/*
  Checker for the three-wire write link between the two ends.
  Assumes host timing defaults: half period of 4 system clocks.
*/
`timescale 1ns/100ps
module serial_write_props (
  input wire logic clk_sys_i, // System clock
  input wire logic reset_n_i, // Sync reset, active low
  input wire logic serial_clk, // Link clock
  input wire logic frame_sync_n, // Frame, active low
  input wire logic serial_data_in // Link data
);
  logic [4:0] falls_reg;
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////
  // Counts link clock falls within a frame
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i || frame_sync_n)
      falls_reg <= 5'h00;
    else if ($fell(serial_clk))
      falls_reg <= falls_reg + 5'h01;
  end
  ////////////////////////////////////////
  a_idle_clock_high: assert property (frame_sync_n |-> serial_clk)
    else $error("link clock low outside a frame");
  a_frame_lead_in: assert property ($fell(frame_sync_n) |-> serial_clk[*4] ##1 !serial_clk)
    else $error("frame lead-in wrong");
  a_low_phase_len: assert property ($fell(serial_clk) |-> !serial_clk[*4] ##1 serial_clk)
    else $error("link clock low phase wrong");
  a_data_steady_low: assert property ($fell(serial_clk) |-> $stable(serial_data_in)[*4])
    else $error("data moved while clock low");
  a_data_on_rise: assert property (!frame_sync_n && !$fell(frame_sync_n) &&
    $changed(serial_data_in) |-> $rose(serial_clk))
    else $error("data moved off a rising edge");
  a_sixteen_falls: assert property ($rose(frame_sync_n) |-> falls_reg == 5'h10)
    else $error("frame closed without sixteen falls");
  a_fall_bound: assert property ($fell(serial_clk) |-> falls_reg < 5'h10)
    else $error("more than sixteen falls in a frame");
  a_frame_gap: assert property ($rose(frame_sync_n) |-> frame_sync_n[*3])
    else $error("frame gap too short");
  c_byte_gap: cover property (falls_reg == 5'h08 && serial_clk[*8]);
  c_frame_end: cover property ($rose(frame_sync_n));
  c_back_to_back: cover property ($rose(frame_sync_n) ##[3:20] $fell(frame_sync_n));
endmodule

// ### test/tb.sv
/*
  Self-checking bench: host and device joined by the link, plus a second
  device driven directly by the bench with broken or odd frames.
*/
`timescale 1ns/100ps
module tb;
  import serial_write_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [15:0] tx_word_i = 16'h0000;
  logic tx_valid_i = 1'b0;
  logic byte_mode_i = 1'b0;
  logic lsb_first_i = 1'b0;
  logic word_ready_i = 1'b0;
  logic bad_ready = 1'b0;
  logic tx_ready_o, busy_o, word_valid_o, overflow_o, bad_valid;
  logic [15:0] word_o, bad_word, w;
  logic [3:0] word_ctrl_o, word_addr_o;
  logic [7:0] word_data_o;
  logic [15:0] exp_q[$];
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  int ovf_cnt = 0;
  serial_write_if link();
  serial_write_if bad_link();
  serial_write_host serial_write_host_i (.clk_sys_i, .reset_n_i, .link(link.host),
    .tx_word_i, .tx_valid_i, .tx_ready_o, .byte_mode_i, .lsb_first_i, .busy_o);
  serial_write_device serial_write_device_i (.clk_sys_i, .reset_n_i, .link(link.device),
    .word_o, .word_ctrl_o, .word_addr_o, .word_data_o, .word_valid_o, .word_ready_i,
    .overflow_o);
  serial_write_device bad_serial_write_device_i (.clk_sys_i, .reset_n_i,
    .link(bad_link.device), .word_o(bad_word), .word_ctrl_o(), .word_addr_o(),
    .word_data_o(), .word_valid_o(bad_valid), .word_ready_i(bad_ready), .overflow_o());
  serial_write_props serial_write_props_i (.clk_sys_i, .reset_n_i,
    .serial_clk(link.serial_clk), .frame_sync_n(link.frame_sync_n),
    .serial_data_in(link.serial_data_in));
  ////////////////////////////////////////
  always #5 clk_sys_i = ~clk_sys_i;
  always @(negedge clk_sys_i) begin
    cycles++;
    if (overflow_o === 1'b1)
      ovf_cnt++;
    if (cycles == 20000) begin
      failures++;
      test_done();
    end
  end
  task automatic test_done();
    if (failures == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [15:0] rev(input logic [15:0] v);
    return {<<{v}};
  endfunction
  task automatic send(input logic [15:0] v, input logic bm, input logic lsb);
    @(posedge clk_sys_i);
    tx_word_i <= v;
    tx_valid_i <= 1'b1;
    byte_mode_i <= bm;
    lsb_first_i <= lsb;
    do @(posedge clk_sys_i); while (tx_ready_o !== 1'b1);
    tx_valid_i <= 1'b0;
  endtask
  task automatic pop(input logic [15:0] e);
    int n = 0;
    @(negedge clk_sys_i);
    while (word_valid_o !== 1'b1 && n < 50) begin
      @(negedge clk_sys_i);
      n++;
    end
    chk("word", word_o, e);
    chk("ctrl", 16'(word_ctrl_o), 16'(e[15:12]));
    chk("addr", 16'(word_addr_o), 16'(e[11:8]));
    chk("data", 16'(word_data_o), 16'(e[7:0]));
    @(posedge clk_sys_i) word_ready_i <= 1'b1;
    @(posedge clk_sys_i) word_ready_i <= 1'b0;
  endtask
  // Bench-made link frame, 125 ns clock, n falls, clock rests at rest
  task automatic raw(input logic [15:0] v, input int n, input logic rest);
    bad_link.serial_clk = rest;
    #100 bad_link.frame_sync_n = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      #62.5 bad_link.serial_clk = 1'b1;
      bad_link.serial_data_in = v[i & 15];
      #62.5 bad_link.serial_clk = 1'b0;
    end
    #62.5 bad_link.serial_clk = rest;
    #100 bad_link.frame_sync_n = 1'b1;
    bad_link.serial_data_in = ~bad_link.serial_data_in;
    repeat (20) @(negedge clk_sys_i);
  endtask
  task automatic bad_pop(input logic [15:0] e);
    chk("bad valid", 16'(bad_valid), 16'h0001);
    chk("bad word", bad_word, e);
    @(posedge clk_sys_i) bad_ready <= 1'b1;
    @(posedge clk_sys_i) bad_ready <= 1'b0;
  endtask
  ////////////////////////////////////////
  initial begin
    bad_link.serial_clk = 1'b1;
    bad_link.frame_sync_n = 1'b1;
    bad_link.serial_data_in = 1'b0;
    repeat (2) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    // Fill past depth with every mode while the consumer stalls
    for (int i = 0; i < 33; i++) begin
      w = 16'(i * 16'h1357 + 16'h8421);
      send(w, i[0], i[1]);
      if (i < 32)
        exp_q.push_back(i[1] ? rev(w) : w);
    end
    do @(negedge clk_sys_i); while (busy_o === 1'b1);
    repeat (30) @(negedge clk_sys_i);
    chk("overflow count", 16'(ovf_cnt), 16'h0001);
    while (exp_q.size() > 0)
      pop(exp_q.pop_front());
    @(negedge clk_sys_i);
    chk("drained valid", 16'(word_valid_o), 16'h0000);
    raw(16'hC3A5, 9, 1'b1);
    chk("partial valid", 16'(bad_valid), 16'h0000);
    raw(16'h5A3C, 16, 1'b0);
    bad_pop(16'h5A3C);
    raw(16'h1234, 48, 1'b1);
    bad_pop(16'h1234);
    @(negedge clk_sys_i);
    chk("extra valid", 16'(bad_valid), 16'h0000);
    test_done();
  end
endmodule
